// >>> hw/dfpc_pkg.sv
`default_nettype none
package dfpc_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 100000000;
	localparam int CLK_NS = 10;
	localparam int I2C_QTR_NS = 1250;
	localparam logic [7:0] I2C_QTR_CYC = 8'(I2C_QTR_NS / CLK_NS);
	localparam int UPD_RATE_HZ = 38000;
	localparam logic [11:0] UPD_GAP_CYC = 12'((CLK_HZ + UPD_RATE_HZ - 1) / UPD_RATE_HZ);

	// ----------------------------------------
	// device register map
	// ----------------------------------------
	// bus address is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2a;
	localparam logic [7:0] REG_LOW = 8'h00;
	localparam logic [7:0] REG_HIGH = 8'h01;
	localparam logic [7:0] REG_PULL = 8'h02;
	localparam int HIGH_W = 10;
	localparam int OE_BIT = 10;
	localparam int PULL_W = 4;
	localparam logic [15:0] RST_LOW = 16'h0000;
	localparam logic [9:0] RST_HIGH = 10'h000;
	localparam logic RST_OE = 1'b0;
	localparam logic [25:0] RST_WORD = 26'h0000000;
	localparam logic [25:0] WORD_NEG_FS = 26'h2000000;
	localparam logic [25:0] WORD_NEG_LIM = 26'h2000001;
	localparam logic [25:0] WORD_POS_FS = 26'h1ffffff;

	// half pull range in quarter ppm, and step in 1e-12, per select code
	localparam logic [15:0][13:0] HALF_RANGE_TAB = {
		14'h3200, 14'h1900, 14'h12c0, 14'h0c80, 14'h0960, 14'h0640, 14'h0320, 14'h0258,
		14'h01f4, 14'h0190, 14'h0140, 14'h00c8, 14'h0064, 14'h0032, 14'h0028, 14'h0019};
	localparam logic [15:0][6:0] STEP_TAB = {
		7'h5e, 7'h2f, 7'h20, 7'h15, 7'h0e, 7'h0a, 7'h05, 7'h05,
		7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05};

	// ----------------------------------------
	// host controller registers
	// ----------------------------------------
	localparam logic [11:0] HA_CTRL = 12'h000;
	localparam logic [11:0] HA_WDATA = 12'h004;
	localparam logic [11:0] HA_STATUS = 12'h008;
	localparam logic [11:0] HA_RDATA = 12'h00c;
	localparam logic [11:0] HA_SHIFT = 12'h010;
	localparam logic [11:0] HA_SPAN = 12'h014;
	localparam logic [11:0] HA_WORD = 12'h018;
	localparam int CTRL_OP_LSB = 8;
	localparam int CTRL_OE_BIT = 10;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_READ = 2'h1;
	localparam logic [1:0] OP_FREQ = 2'h2;
	localparam logic [1:0] T_WR = 2'h0;
	localparam logic [1:0] T_PTR = 2'h1;
	localparam logic [1:0] T_RD = 2'h2;
	localparam logic [5:0] DIV_STEPS = 6'h2a;
endpackage
`default_nettype wire

// >>> hw/dfpc_i2c_if.sv
`default_nettype none
interface dfpc_i2c_if;
	logic scl_o;
	logic scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;

	// open drain with pull-up
	assign scl = ~(scl_oe & ~scl_o);
	assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

	modport host (input scl, input sda, output scl_o, output scl_oe, output h_sda_o, output h_sda_oe);
	modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface
`default_nettype wire

// >>> hw/dfpc_dev.sv
// Contract
// R1 - power-up: nominal frequency, factory pull range
// R2 - range and offset writable over serial link
// R3 - deviation never exceeds selected pull range
// R4 - sixteen ranges, 6.25 to 3200 ppm
// R5 - step 5e-12 up to 200 ppm, coarser above
// R6 - offset is 26-bit two's complement
// R7 - offset resets to zero
// R8 - low bits at 0x00, high at 0x01[9:0]
// R9 - only high word write changes output
// R10 - host writes low word before high word
// R11 - host rounds 33554431 times shift over range
// R12 - host updates no faster than 38 kHz
// R13 - enable bit only under software control
// R14 - host sets enable bit with high word
// R15 - pull select is 0x02[3:0], read/write
// R16 - enable bit resets 0, 1 enables
// R17 - unused upper bits read zero
// R18 - pull select starts at factory value
// R19 - offset committed whole on high write
`default_nettype none
module dfpc_dev (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	dfpc_i2c_if.dev LINK,
	input wire logic [3:0] FACTORY_PULL,
	input wire logic OE_SW_CTRL,
	input wire logic OE_PIN,
	output logic [25:0] FREQ_OFFSET,
	output logic [3:0] PULL_SEL,
	output logic [13:0] HALF_RANGE_QPPM,
	output logic [6:0] STEP_PPT,
	output logic OUT_EN,
	output logic UPDATE
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_ADDR = 3'b001,
		D_PTR = 3'b010,
		D_WR = 3'b011,
		D_RD = 3'b100,
		D_IGN = 3'b101
	} dfpc_dev_st_t;

	// ----------------------------------------
	// state
	// ----------------------------------------
	dfpc_dev_st_t st_r, st_nxt;
	logic scl_q_r, scl_q_nxt;
	logic sda_q_r, sda_q_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] ob_r, ob_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic [7:0] hi_r, hi_nxt;
	logic hb_r, hb_nxt;
	logic sda_oe_r, sda_oe_nxt;
	logic [15:0] low_r, low_nxt;
	logic [9:0] high_r, high_nxt;
	logic oe_r, oe_nxt;
	logic [3:0] pull_r, pull_nxt;
	logic [25:0] off_r, off_nxt;
	logic [13:0] rng_r, rng_nxt;
	logic [6:0] step_r, step_nxt;
	logic out_en_r, out_en_nxt;
	logic upd_r, upd_nxt;
	logic rise, fall, start, stop, wr;
	logic [15:0] rd_word, wd;
	logic [25:0] cw;

	assign LINK.d_sda_o = 1'b0;
	assign LINK.d_sda_oe = sda_oe_r;
	assign FREQ_OFFSET = off_r;
	assign PULL_SEL = pull_r;
	assign HALF_RANGE_QPPM = rng_r;
	assign STEP_PPT = step_r;
	assign OUT_EN = out_en_r;
	assign UPDATE = upd_r;

	// ----------------------------------------
	// link slave and register file
	// ----------------------------------------
	always_comb begin
		rise = LINK.scl & ~scl_q_r;
		fall = ~LINK.scl & scl_q_r;
		start = LINK.scl & scl_q_r & sda_q_r & ~LINK.sda;
		stop = LINK.scl & scl_q_r & ~sda_q_r & LINK.sda;
		scl_q_nxt = LINK.scl;
		sda_q_nxt = LINK.sda;
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ob_nxt = ob_r;
		ptr_nxt = ptr_r;
		hi_nxt = hi_r;
		hb_nxt = hb_r;
		sda_oe_nxt = sda_oe_r;
		low_nxt = low_r;
		high_nxt = high_r;
		oe_nxt = oe_r;
		pull_nxt = pull_r;
		off_nxt = off_r;
		upd_nxt = 1'b0;
		wr = 1'b0;
		wd = {hi_r, sh_r};
		cw = {wd[dfpc_pkg::HIGH_W-1:0], low_r};
		case (ptr_r)
			dfpc_pkg::REG_LOW: rd_word = low_r;
			dfpc_pkg::REG_HIGH: rd_word = 16'({oe_r, high_r}); // R17
			dfpc_pkg::REG_PULL: rd_word = 16'(pull_r); // R15 R17
			default: rd_word = 16'h0000;
		endcase
		if (start) begin
			st_nxt = D_ADDR;
			// the scl fall that closes the start wraps this to zero
			cnt_nxt = 4'hf;
			hb_nxt = 1'b1;
			sda_oe_nxt = 1'b0;
		end else if (stop) begin
			st_nxt = D_IDLE;
			sda_oe_nxt = 1'b0;
		end else if (st_r != D_IDLE && st_r != D_IGN) begin
			if (rise) begin
				if (cnt_r != 4'h8) begin
					sh_nxt = {sh_r[6:0], LINK.sda};
				end else if (st_r == D_RD && LINK.sda) begin
					// host refused more data
					st_nxt = D_IGN;
				end
			end
			if (fall) begin
				if (cnt_r == 4'h8) begin
					cnt_nxt = 4'h0;
					sda_oe_nxt = 1'b0;
					if (st_r == D_RD) begin
						ob_nxt = hb_r ? rd_word[15:8] : rd_word[7:0];
						sda_oe_nxt = hb_r ? ~rd_word[15] : ~rd_word[7];
						hb_nxt = ~hb_r;
					end
				end else if (cnt_r == 4'h7) begin
					cnt_nxt = 4'h8;
					sda_oe_nxt = st_r != D_RD;
					case (st_r)
						D_ADDR: begin
							if (sh_r[7:1] != dfpc_pkg::DEV_ADDR) begin
								st_nxt = D_IGN;
								sda_oe_nxt = 1'b0;
							end else if (sh_r[0]) begin
								st_nxt = D_RD;
							end else begin
								st_nxt = D_PTR;
							end
						end
						D_PTR: begin
							ptr_nxt = sh_r;
							st_nxt = D_WR;
						end
						D_WR: begin
							if (hb_r) begin
								hi_nxt = sh_r;
							end else begin
								wr = 1'b1;
							end
							hb_nxt = ~hb_r;
						end
						default: begin
						end
					endcase
				end else begin
					cnt_nxt = cnt_r + 4'h1;
					if (st_r == D_RD) begin
						ob_nxt = {ob_r[6:0], 1'b0};
						sda_oe_nxt = ~ob_r[6];
					end
				end
			end
		end
		if (wr) begin // R2
			case (ptr_r)
				dfpc_pkg::REG_LOW: begin
					low_nxt = wd; // R8 R9
				end
				dfpc_pkg::REG_HIGH: begin
					high_nxt = wd[dfpc_pkg::HIGH_W-1:0]; // R8
					if (OE_SW_CTRL) begin
						oe_nxt = wd[dfpc_pkg::OE_BIT]; // R13
					end
					// full-scale negative word trimmed to the range limit
					off_nxt = (cw == dfpc_pkg::WORD_NEG_FS) ? dfpc_pkg::WORD_NEG_LIM : cw; // R3 R6 R9 R19
					upd_nxt = 1'b1;
				end
				dfpc_pkg::REG_PULL: begin
					pull_nxt = wd[dfpc_pkg::PULL_W-1:0]; // R15
				end
				default: begin
				end
			endcase
		end
		rng_nxt = dfpc_pkg::HALF_RANGE_TAB[pull_r]; // R3 R4
		step_nxt = dfpc_pkg::STEP_TAB[pull_r]; // R5
		out_en_nxt = OE_SW_CTRL ? oe_r : OE_PIN; // R13 R16
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			st_r <= D_IDLE;
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			ob_r <= 8'h00;
			ptr_r <= 8'h00;
			hi_r <= 8'h00;
			hb_r <= 1'b1;
			sda_oe_r <= 1'b0;
			low_r <= dfpc_pkg::RST_LOW; // R7
			high_r <= dfpc_pkg::RST_HIGH; // R7
			oe_r <= dfpc_pkg::RST_OE; // R16
			pull_r <= FACTORY_PULL; // R1 R18
			off_r <= dfpc_pkg::RST_WORD; // R1 R7
			rng_r <= 14'h0000;
			step_r <= 7'h00;
			out_en_r <= 1'b0;
			upd_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			scl_q_r <= scl_q_nxt;
			sda_q_r <= sda_q_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ob_r <= ob_nxt;
			ptr_r <= ptr_nxt;
			hi_r <= hi_nxt;
			hb_r <= hb_nxt;
			sda_oe_r <= sda_oe_nxt;
			low_r <= low_nxt;
			high_r <= high_nxt;
			oe_r <= oe_nxt;
			pull_r <= pull_nxt;
			off_r <= off_nxt;
			rng_r <= rng_nxt;
			step_r <= step_nxt;
			out_en_r <= out_en_nxt;
			upd_r <= upd_nxt;
		end
	end
endmodule // dfpc_dev
`default_nettype wire

// >>> hw/dfpc_host.sv
`default_nettype none
module dfpc_host (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	dfpc_i2c_if.host LINK
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_DIV = 3'b001,
		H_START = 3'b010,
		H_BIT = 3'b011,
		H_STOP = 3'b100,
		H_GAP = 3'b101
	} dfpc_host_st_t;

	dfpc_host_st_t st_r, st_nxt;
	logic [10:0] ctrl_r, ctrl_nxt;
	logic [15:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, shift_r, shift_nxt;
	logic [13:0] span_r, span_nxt;
	logic [25:0] word_r, word_nxt, q_r, q_nxt;
	logic [41:0] n_r, n_nxt;
	logic [14:0] rem_r, rem_nxt;
	logic [5:0] dcnt_r, dcnt_nxt;
	logic [7:0] qcnt_r, qcnt_nxt, sh_r, sh_nxt;
	logic [1:0] ph_r, ph_nxt, bidx_r, bidx_nxt, tr_r, tr_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic sub_r, sub_nxt, nack_r, nack_nxt, scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
	logic [11:0] gap_r, gap_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic tick, rcv, mapped, acc;
	logic [1:0] last;
	logic [7:0] treg, tbyte, bsrc;
	logic [15:0] tdata, mag, r2, dv;

	assign LINK.scl_o = 1'b0;
	assign LINK.h_sda_o = 1'b0;
	assign LINK.scl_oe = scl_oe_r;
	assign LINK.h_sda_oe = sda_oe_r;
	assign PRDATA = prdata_r;
	assign PREADY = pready_r;
	assign PSLVERR = pslverr_r;

	always_comb begin
		st_nxt = st_r;
		{ctrl_nxt, wdata_nxt, rdata_nxt, shift_nxt, span_nxt} = {ctrl_r, wdata_r, rdata_r, shift_r, span_r};
		{word_nxt, q_nxt, n_nxt, rem_nxt, dcnt_nxt, sh_nxt} = {word_r, q_r, n_r, rem_r, dcnt_r, sh_r};
		{ph_nxt, bidx_nxt, tr_nxt, bit_nxt, sub_nxt, nack_nxt} = {ph_r, bidx_r, tr_r, bit_r, sub_r, nack_r};
		{scl_oe_nxt, sda_oe_nxt, gap_nxt} = {scl_oe_r, sda_oe_r, gap_r};
		tick = qcnt_r == 8'h00;
		qcnt_nxt = tick ? dfpc_pkg::I2C_QTR_CYC - 8'h01 : qcnt_r - 8'h01;
		// ----------------------------------------
		// apb slave, zero wait states
		// ----------------------------------------
		mapped = PADDR <= dfpc_pkg::HA_WORD && PADDR[1:0] == 2'h0;
		acc = PSEL & PENABLE & pready_r;
		pready_nxt = PSEL & ~PENABLE;
		pslverr_nxt = PSEL & ~PENABLE & ~mapped;
		case (PADDR)
			dfpc_pkg::HA_CTRL: prdata_nxt = 32'(ctrl_r);
			dfpc_pkg::HA_WDATA: prdata_nxt = 32'(wdata_r);
			dfpc_pkg::HA_STATUS: prdata_nxt = 32'({nack_r, st_r != H_IDLE});
			dfpc_pkg::HA_RDATA: prdata_nxt = 32'(rdata_r);
			dfpc_pkg::HA_SHIFT: prdata_nxt = 32'(shift_r);
			dfpc_pkg::HA_SPAN: prdata_nxt = 32'(span_r);
			dfpc_pkg::HA_WORD: prdata_nxt = 32'(word_r);
			default: prdata_nxt = 32'h00000000;
		endcase
		if (acc && PWRITE) begin
			case (PADDR)
				dfpc_pkg::HA_WDATA: wdata_nxt = PWDATA[15:0];
				dfpc_pkg::HA_SHIFT: shift_nxt = PWDATA[15:0];
				dfpc_pkg::HA_SPAN: span_nxt = PWDATA[13:0];
				default: begin
				end
			endcase
		end
		// ----------------------------------------
		// byte source of the current transfer
		// ----------------------------------------
		treg = ctrl_r[7:0];
		tdata = wdata_r;
		if (ctrl_r[9:8] == dfpc_pkg::OP_FREQ) begin
			treg = sub_r ? dfpc_pkg::REG_HIGH : dfpc_pkg::REG_LOW; // R10
			tdata = sub_r ? 16'({ctrl_r[dfpc_pkg::CTRL_OE_BIT], word_r[25:16]}) : word_r[15:0]; // R14
		end
		case (bidx_r)
			2'h0: tbyte = {dfpc_pkg::DEV_ADDR, tr_r == dfpc_pkg::T_RD};
			2'h1: tbyte = treg;
			2'h2: tbyte = tdata[15:8];
			default: tbyte = tdata[7:0];
		endcase
		last = (tr_r == dfpc_pkg::T_WR) ? 2'h3 : (tr_r == dfpc_pkg::T_PTR) ? 2'h1 : 2'h2;
		rcv = tr_r == dfpc_pkg::T_RD && bidx_r != 2'h0;
		bsrc = (bit_r == 4'h0) ? tbyte : sh_r;
		mag = shift_r[15] ? 16'(-shift_r) : shift_r;
		if (mag > 16'(span_r)) begin
			mag = 16'(span_r);
		end
		r2 = {rem_r, n_r[41]};
		dv = {1'b0, span_r, 1'b0};
		// ----------------------------------------
		// sequencer
		// ----------------------------------------
		case (st_r)
			H_IDLE: begin
				if (acc && PWRITE && PADDR == dfpc_pkg::HA_CTRL) begin
					ctrl_nxt = PWDATA[10:0];
					nack_nxt = 1'b0;
					sub_nxt = 1'b0;
					ph_nxt = 2'h0;
					tr_nxt = (PWDATA[9:8] == dfpc_pkg::OP_READ) ? dfpc_pkg::T_PTR : dfpc_pkg::T_WR;
					st_nxt = (PWDATA[9:8] == dfpc_pkg::OP_FREQ) ? H_DIV : H_START;
					// rounded: (2*min(|s|,span)*(2^25-1) + span) / (2*span)
					n_nxt = {41'({mag, 25'h0}) - 41'(mag), 1'b0} + 42'(span_r); // R11
					rem_nxt = 15'h0000;
					q_nxt = 26'h0000000;
					dcnt_nxt = dfpc_pkg::DIV_STEPS;
				end
			end
			H_DIV: begin
				if (dcnt_r == 6'h00) begin
					word_nxt = (span_r == 14'h0000) ? 26'h0000000 : shift_r[15] ? 26'(-q_r) : q_r; // R11
					st_nxt = H_START;
				end else begin
					rem_nxt = (r2 >= dv) ? 15'(r2 - dv) : r2[14:0];
					q_nxt = {q_r[24:0], r2 >= dv};
					n_nxt = {n_r[40:0], 1'b0};
					dcnt_nxt = dcnt_r - 6'h01;
				end
			end
			H_START: begin
				if (tick) begin
					ph_nxt = ph_r + 2'h1;
					case (ph_r)
						2'h0: {scl_oe_nxt, sda_oe_nxt} = 2'b00;
						2'h1: sda_oe_nxt = 1'b1;
						2'h2: scl_oe_nxt = 1'b1;
						default: begin
							st_nxt = H_BIT;
							bidx_nxt = 2'h0;
							bit_nxt = 4'h0;
						end
					endcase
				end
			end
			H_BIT: begin
				if (tick) begin
					ph_nxt = ph_r + 2'h1;
					case (ph_r)
						2'h0: begin
							sh_nxt = bsrc;
							sda_oe_nxt = bit_r[3] ? (rcv && bidx_r != last) : (~rcv & ~bsrc[7]);
						end
						2'h1: scl_oe_nxt = 1'b0;
						2'h2: begin
							if (!bit_r[3]) begin
								sh_nxt = {sh_r[6:0], LINK.sda};
							end else if (!rcv && LINK.sda) begin
								nack_nxt = 1'b1;
							end
						end
						default: begin
							scl_oe_nxt = 1'b1;
							if (!bit_r[3]) begin
								bit_nxt = bit_r + 4'h1;
							end else begin
								bit_nxt = 4'h0;
								if (rcv) begin
									rdata_nxt = {rdata_r[7:0], sh_r};
								end
								if (nack_r || bidx_r == last) begin
									st_nxt = H_STOP;
								end else begin
									bidx_nxt = bidx_r + 2'h1;
								end
							end
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					ph_nxt = ph_r + 2'h1;
					case (ph_r)
						2'h0: sda_oe_nxt = 1'b1;
						2'h1: scl_oe_nxt = 1'b0;
						2'h2: sda_oe_nxt = 1'b0;
						default: begin
							st_nxt = H_IDLE;
							if (nack_r) begin
								st_nxt = H_IDLE;
							end else if (ctrl_r[9:8] == dfpc_pkg::OP_READ && tr_r == dfpc_pkg::T_PTR) begin
								tr_nxt = dfpc_pkg::T_RD;
								st_nxt = H_START;
							end else if (ctrl_r[9:8] == dfpc_pkg::OP_FREQ && !sub_r) begin
								sub_nxt = 1'b1; // R10
								st_nxt = H_START;
							end else if (tr_r == dfpc_pkg::T_WR && treg == dfpc_pkg::REG_HIGH) begin
								gap_nxt = dfpc_pkg::UPD_GAP_CYC; // R12
								st_nxt = H_GAP;
							end
						end
					endcase
				end
			end
			H_GAP: begin
				gap_nxt = gap_r - 12'h001;
				if (gap_r == 12'h001) begin
					st_nxt = H_IDLE; // R12
				end
			end
			default: st_nxt = H_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			st_r <= H_IDLE;
			{ctrl_r, wdata_r, rdata_r, shift_r, span_r} <= {11'h000, 16'h0000, 16'h0000, 16'h0000, 14'h0000};
			{word_r, q_r, n_r, rem_r, dcnt_r, sh_r} <= {26'h0000000, 26'h0000000, 42'h0, 15'h0000, 6'h00, 8'h00};
			{ph_r, bidx_r, tr_r, bit_r, sub_r, nack_r} <= {2'h0, 2'h0, 2'h0, 4'h0, 1'b0, 1'b0};
			{scl_oe_r, sda_oe_r, gap_r, qcnt_r} <= {1'b0, 1'b0, 12'h000, 8'h00};
			{prdata_r, pready_r, pslverr_r} <= {32'h00000000, 1'b0, 1'b0};
		end else begin
			st_r <= st_nxt;
			{ctrl_r, wdata_r, rdata_r, shift_r, span_r} <= {ctrl_nxt, wdata_nxt, rdata_nxt, shift_nxt, span_nxt};
			{word_r, q_r, n_r, rem_r, dcnt_r, sh_r} <= {word_nxt, q_nxt, n_nxt, rem_nxt, dcnt_nxt, sh_nxt};
			{ph_r, bidx_r, tr_r, bit_r, sub_r, nack_r} <= {ph_nxt, bidx_nxt, tr_nxt, bit_nxt, sub_nxt, nack_nxt};
			{scl_oe_r, sda_oe_r, gap_r, qcnt_r} <= {scl_oe_nxt, sda_oe_nxt, gap_nxt, qcnt_nxt};
			{prdata_r, pready_r, pslverr_r} <= {prdata_nxt, pready_nxt, pslverr_nxt};
		end
	end
endmodule // dfpc_host
`default_nettype wire

// >>> dv/dfpc_assertions.sv
`default_nettype none
module dfpc_assertions (
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	input wire logic scl_o,
	input wire logic h_sda_o,
	input wire logic d_sda_o,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic [3:0] FACTORY_PULL,
	input wire logic OE_SW_CTRL,
	input wire logic OE_PIN,
	input wire logic [25:0] FREQ_OFFSET,
	input wire logic [3:0] PULL_SEL,
	input wire logic [13:0] HALF_RANGE_QPPM,
	input wire logic [6:0] STEP_PPT,
	input wire logic OUT_EN,
	input wire logic UPDATE
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RESET_N);
	// ----------------------------------------
	// link wire
	// ----------------------------------------
	a_drive_low_only: assert property (!scl_o && !h_sda_o && !d_sda_o)
		else $error("open drain line driven high");
	a_dev_sda_scl_low: assert property ($changed(d_sda_oe) |-> !scl)
		else $error("device moved sda while scl high");
	// ----------------------------------------
	// device outputs
	// ----------------------------------------
	a_reset_values: assert property ($rose(RESET_N) |->
		FREQ_OFFSET == 26'h0 && !OUT_EN && PULL_SEL == $past(FACTORY_PULL))
		else $error("wrong state after reset");
	a_offset_on_update: assert property (!$stable(FREQ_OFFSET) |-> UPDATE)
		else $error("offset changed without commit");
	a_never_neg_fs: assert property (FREQ_OFFSET != dfpc_pkg::WORD_NEG_FS)
		else $error("offset beyond range limit");
	a_range_table: assert property ($past(RESET_N) |->
		HALF_RANGE_QPPM == dfpc_pkg::HALF_RANGE_TAB[$past(PULL_SEL)])
		else $error("half range does not match select");
	a_step_table: assert property ($past(RESET_N) |-> STEP_PPT == dfpc_pkg::STEP_TAB[$past(PULL_SEL)])
		else $error("step does not match select");
	a_oe_pin_ctrl: assert property (!OE_SW_CTRL && $past(RESET_N) |-> OUT_EN == $past(OE_PIN))
		else $error("enable not following pin");
	a_oe_sw_commit: assert property (OE_SW_CTRL && $changed(OUT_EN) |->
		$past(UPDATE) || $past(UPDATE, 2))
		else $error("software enable moved without commit");
	a_update_pulse: assert property (UPDATE |=> !UPDATE [*8])
		else $error("commit pulses too close");
	c_update: cover property (UPDATE);
	c_out_en: cover property ($rose(OUT_EN));
	c_ack: cover property ($rose(d_sda_oe));
endmodule // dfpc_assertions
`default_nettype wire

// >>> dv/test_digital_freq_pull_control.sv
`default_nettype none
module test_digital_freq_pull_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, reset_n, psel, penable, pwrite, oe_sw_ctrl, oe_pin, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] factory_pull, pull_sel;
	logic [25:0] freq_offset, exp_w;
	logic [13:0] half_range;
	logic [6:0] step_ppt;
	logic out_en, update;
	int n_fail, total_checks, n_upd, s, code;
	int ppm4[16] = '{25, 40, 50, 100, 200, 320, 400, 500, 600, 800, 1600, 2400, 3200, 4800, 6400, 12800};
	int stp[16] = '{5, 5, 5, 5, 5, 5, 5, 5, 5, 5, 10, 14, 21, 32, 47, 94};
	dfpc_i2c_if dfpc_i2c_if_i();
	dfpc_dev dfpc_dev_i(.CLK_SYS(clk_sys), .RESET_N(reset_n), .LINK(dfpc_i2c_if_i), .FACTORY_PULL(factory_pull),
		.OE_SW_CTRL(oe_sw_ctrl), .OE_PIN(oe_pin), .FREQ_OFFSET(freq_offset), .PULL_SEL(pull_sel),
		.HALF_RANGE_QPPM(half_range), .STEP_PPT(step_ppt), .OUT_EN(out_en), .UPDATE(update));
	dfpc_host dfpc_host_i(.CLK_SYS(clk_sys), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.LINK(dfpc_i2c_if_i));
	dfpc_assertions dfpc_assertions_i(.CLK_SYS(clk_sys), .RESET_N(reset_n), .scl_o(dfpc_i2c_if_i.scl_o),
		.h_sda_o(dfpc_i2c_if_i.h_sda_o), .d_sda_o(dfpc_i2c_if_i.d_sda_o), .d_sda_oe(dfpc_i2c_if_i.d_sda_oe),
		.scl(dfpc_i2c_if_i.scl), .FACTORY_PULL(factory_pull), .OE_SW_CTRL(oe_sw_ctrl), .OE_PIN(oe_pin),
		.FREQ_OFFSET(freq_offset), .PULL_SEL(pull_sel), .HALF_RANGE_QPPM(half_range), .STEP_PPT(step_ppt),
		.OUT_EN(out_en), .UPDATE(update));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (update === 1'b1)
			n_upd++;
	end
	// rounded, clamped control word from shift and half span in quarter ppm
	function automatic logic [25:0] mdl_word(int sh, int span);
		longint m;
		m = (sh < 0) ? -sh : sh;
		if (span == 0)
			return 26'h0;
		if (m > span)
			m = span;
		m = (2 * m * 33554431 + span) / (2 * span);
		if (sh < 0)
			m = -m;
		return m[25:0];
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_idle;
		for (int i = 0; i < 60000; i++) begin
			apb(1'b0, dfpc_pkg::HA_STATUS, 32'h0);
			if (rd[0] === 1'b0)
				break;
		end
		chk(32'(rd[1:0]), 32'h0);
	endtask
	task do_reset(input logic sw, input logic [3:0] fp);
		reset_n <= 1'b0;
		oe_sw_ctrl <= sw;
		factory_pull <= fp;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		// reset values still stand until the next edge
		#1;
		chk(32'(freq_offset), 32'h0);
		chk(32'(out_en), 32'h0);
		chk(32'(pull_sel), 32'(fp));
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'(half_range), 32'(ppm4[fp]));
		chk(32'(step_ppt), 32'(stp[fp]));
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// link traffic of all tests takes about 85k cycles
	initial begin
		#950000;
		n_fail++;
		summarize();
	end
	initial begin
		{reset_n, psel, penable, pwrite, paddr, pwdata, oe_sw_ctrl, factory_pull} = '0;
		oe_pin = 1'b1;
		{n_fail, total_checks, n_upd} = '0;
		void'($urandom(64));
		do_reset(1'b1, 4'h9);
		$display("test reset done");
		apb(1'b0, 12'h01c, 32'h0);
		chk(32'(er), 32'h1);
		apb(1'b1, 12'h002, 32'h0);
		chk(32'(er), 32'h1);
		apb(1'b1, dfpc_pkg::HA_SHIFT, 32'h0000a5c3);
		apb(1'b0, dfpc_pkg::HA_SHIFT, 32'h0);
		chk(rd, 32'h0000a5c3);
		$display("test registers done");
		s = -(ppm4[9] + $urandom_range(50, 0));
		exp_w = mdl_word(s, ppm4[9]);
		apb(1'b1, dfpc_pkg::HA_SHIFT, 32'(16'(s)));
		apb(1'b1, dfpc_pkg::HA_SPAN, 32'(ppm4[9]));
		n_upd = 0;
		apb(1'b1, dfpc_pkg::HA_CTRL, 32'h00000600);
		wait_idle();
		chk(32'(freq_offset), 32'(exp_w));
		apb(1'b0, dfpc_pkg::HA_WORD, 32'h0);
		chk(rd, 32'(exp_w));
		chk(32'(out_en), 32'h1);
		chk(32'(n_upd), 32'h1);
		$display("test frequency done");
		code = $urandom_range(15, 10);
		apb(1'b1, dfpc_pkg::HA_WDATA, 32'h0000fff0 | 32'(code));
		apb(1'b1, dfpc_pkg::HA_CTRL, 32'h00000002);
		wait_idle();
		chk(32'(pull_sel), 32'(code));
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'(half_range), 32'(ppm4[code]));
		chk(32'(step_ppt), 32'(stp[code]));
		chk(32'(freq_offset), 32'(exp_w));
		chk(32'(n_upd), 32'h1);
		// read back the pull select register, upper bits were written as ones
		apb(1'b1, dfpc_pkg::HA_CTRL, 32'h00000102);
		wait_idle();
		apb(1'b0, dfpc_pkg::HA_RDATA, 32'h0);
		chk(rd, 32'(code));
		$display("test pull select done");
		do_reset(1'b0, 4'($urandom_range(15, 0)));
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			oe_pin <= i[0];
			@(posedge clk_sys);
			#1;
			chk(32'(out_en), 32'(i[0]));
		end
		$display("test pin enable done");
		summarize();
	end
endmodule // test_digital_freq_pull_control
`default_nettype wire
